//--- hdl/ddt_pkg.sv
`default_nettype none
package ddt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int unsigned AW       = 12;
  localparam int unsigned DW       = 32;
  localparam int unsigned OFS_W    = 5;
  localparam int unsigned TSEL_BIT = 5;
  localparam int unsigned CTRL_W   = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets inside one timer bank, banks at 0x00 and 0x20
  localparam logic [OFS_W-1:0] OFS_LOAD   = 5'h00;
  localparam logic [OFS_W-1:0] OFS_VALUE  = 5'h04;
  localparam logic [OFS_W-1:0] OFS_CTRL   = 5'h08;
  localparam logic [OFS_W-1:0] OFS_INTCLR = 5'h0c;
  localparam logic [OFS_W-1:0] OFS_RIS    = 5'h10;
  localparam logic [OFS_W-1:0] OFS_MIS    = 5'h14;
  localparam logic [OFS_W-1:0] OFS_BGLOAD = 5'h18;
  localparam logic [AW-1:0]    ADDR_ID0   = 12'hfe0;
  localparam logic [AW-1:0]    ADDR_ID1   = 12'hfe4;

  ////////////////////////////////////////////////////////////////////////////
  // Control field positions and reset values
  localparam int unsigned CTL_SINGLE_RUN_SELECT  = 0;
  localparam int unsigned CTL_SIZE32   = 1;
  localparam int unsigned CTL_PRE_LO   = 2;
  localparam int unsigned CTL_PRE_HI   = 3;
  localparam int unsigned CTL_INTEN    = 5;
  localparam int unsigned CTL_PERIODIC = 6;
  localparam int unsigned CTL_EN       = 7;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h20;
  localparam logic [DW-1:0]     LOAD_RST  = 32'h0000_0000;
  localparam logic [DW-1:0]     VALUE_RST = 32'h0fff_ffff;
  localparam logic [DW-1:0]     WRAP32    = 32'h0fff_ffff;

  ////////////////////////////////////////////////////////////////////////////
  // Counter halves and prescaler
  localparam int unsigned HALF     = 16;
  localparam logic [HALF-1:0] LOW_MAX  = 16'hffff;
  localparam logic [HALF-1:0] LOW_ONE  = 16'h0001;
  localparam logic [DW-1:0]   FULL_ONE = 32'h0000_0001;
  localparam int unsigned PRE_W    = 8;
  localparam int unsigned PRE16_W  = 4;
  localparam logic [1:0]  PRE_DIV1   = 2'h0;
  localparam logic [1:0]  PRE_DIV16  = 2'h1;
  localparam logic [PRE16_W-1:0] PRE16_TERM  = 4'hf;
  localparam logic [PRE_W-1:0]   PRE256_TERM = 8'hff;
  localparam logic [PRE_W-1:0]   PRE_ONE     = 8'h01;

  // Zero test honours the counter size; upper half ignored in 16-bit mode
  function automatic logic is_zero(input logic [DW-1:0] v, input logic s32);
    is_zero = s32 ? (v == '0) : (v[HALF-1:0] == '0);
  endfunction

endpackage
`default_nettype wire

//--- hdl/ddt_counter_unit.sv
`timescale 1ns/1ps
`default_nettype none
module ddt_counter_unit import ddt_pkg::*; (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          tick,
  input  wire logic          en,
  input  wire logic          single_run_select,
  input  wire logic          periodic,
  input  wire logic          size32,
  input  wire logic [1:0]    pre_sel,
  input  wire logic          int_en,
  input  wire logic          load_wr,
  input  wire logic          bg_wr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          int_clr,
  output logic      [DW-1:0] cnt_r,
  output logic      [DW-1:0] load_r,
  output logic               raw_r,
  output logic               irq_r
);

  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] pre_nxt;
  logic             pend_r;
  logic             pend_nxt;
  logic             stop_r;
  logic             stop_nxt;
  logic [DW-1:0]    cnt_nxt;
  logic [DW-1:0]    load_nxt;
  logic             raw_nxt;
  logic             irq_nxt;
  logic             apply;
  logic             pre_hit;
  logic             step;
  logic             zero_hit;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    // A load written in the same cycle as a tick waits for the next tick
    apply = pend_r & tick & ~load_wr;                                  // [R7]
    case (pre_sel)                                                     // [R6]
      PRE_DIV1:  pre_hit = 1'b1;
      PRE_DIV16: pre_hit = (pre_r[PRE16_W-1:0] == PRE16_TERM);
      default:   pre_hit = (pre_r == PRE256_TERM);
    endcase
    step     = tick & en & pre_hit & ~stop_r & ~apply;                 // [R16]
    zero_hit = step & is_zero(cnt_r, size32);
    pre_nxt  = pre_r;
    if (apply) begin
      pre_nxt = '0;
    end else if (tick & en) begin                                      // [R15]
      pre_nxt = pre_r + PRE_ONE;
    end
    pend_nxt = load_wr | (pend_r & ~apply);
    load_nxt = (load_wr | bg_wr) ? wdata : load_r;                     // [R8]
    cnt_nxt  = cnt_r;
    stop_nxt = stop_r;
    if (apply) begin
      cnt_nxt  = load_r;                                               // [R7]
      stop_nxt = 1'b0;
    end else if (zero_hit) begin
      if (single_run_select) begin                                               // [R23]
        stop_nxt = 1'b1;                                               // [R4]
      end else if (periodic) begin                                     // [R3]
        cnt_nxt = size32 ? load_r : {cnt_r[DW-1:HALF], load_r[HALF-1:0]};
      end else begin                                                   // [R2]
        cnt_nxt = size32 ? WRAP32 : {cnt_r[DW-1:HALF], LOW_MAX};       // [R22]
      end
    end else if (step) begin                                           // [R1]
      cnt_nxt = size32 ? cnt_r - FULL_ONE
                       : {cnt_r[DW-1:HALF], cnt_r[HALF-1:0] - LOW_ONE};
    end
    // Set wins over a clear in the same cycle
    raw_nxt = zero_hit | (raw_r & ~int_clr);                           // [R9]
    irq_nxt = raw_nxt & int_en;                                        // [R10]
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_r  <= '0;                                                    // [R14]
      pend_r <= 1'b0;
      stop_r <= 1'b0;
      cnt_r  <= VALUE_RST;
      load_r <= LOAD_RST;
      raw_r  <= 1'b0;
      irq_r  <= 1'b0;
    end else begin
      pre_r  <= pre_nxt;
      pend_r <= pend_nxt;
      stop_r <= stop_nxt;
      cnt_r  <= cnt_nxt;
      load_r <= load_nxt;
      raw_r  <= raw_nxt;
      irq_r  <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_load_apply;
    @(posedge clk) disable iff (!rst_b) apply |=> cnt_r == $past(load_r);
  endproperty
  a_load_apply: assert property (p_load_apply) else $error("load not applied"); // [R7]

  property p_zero_int;
    @(posedge clk) disable iff (!rst_b) zero_hit |=> raw_r;
  endproperty
  a_zero_int: assert property (p_zero_int) else $error("zero without irq"); // [R9]

  property p_clear;
    @(posedge clk) disable iff (!rst_b) int_clr && !zero_hit |=> !raw_r && !irq_r;
  endproperty
  a_clear: assert property (p_clear) else $error("clear ignored"); // [R21]

  property p_hold;
    @(posedge clk) disable iff (!rst_b) !step && !apply |=> $stable(cnt_r);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved without step"); // [R16]

  property p_wrap16;
    @(posedge clk) disable iff (!rst_b)
      zero_hit && !single_run_select && !periodic && !size32 |=> cnt_r[HALF-1:0] == LOW_MAX;
  endproperty
  a_wrap16: assert property (p_wrap16) else $error("16-bit wrap wrong"); // [R22]

  property p_single_run_select;
    @(posedge clk) disable iff (!rst_b)
      zero_hit && single_run_select ##1 !pend_r [*2] |-> $stable(cnt_r);
  endproperty
  a_single_run_select: assert property (p_single_run_select) else $error("one-shot restarted"); // [R4]

  property p_periodic;
    @(posedge clk) disable iff (!rst_b)
      zero_hit && periodic && !single_run_select && size32 |=> cnt_r == $past(load_r);
  endproperty
  a_periodic: assert property (p_periodic) else $error("reload wrong"); // [R3]

  property p_bgload;
    @(posedge clk) disable iff (!rst_b)
      bg_wr && !load_wr |=> load_r == $past(wdata) && !$rose(pend_r);
  endproperty
  a_bgload: assert property (p_bgload) else $error("background load wrong"); // [R8]

endmodule
`default_nettype wire

//--- hdl/ddt_top.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1: Two identical down counters, each selectable as 32-bit or 16-bit.
// R2: Free-running mode wraps to the maximum value on reaching zero; in 32-bit mode the code wraps to 0x0fffffff (WRAP32).
// R3: Periodic mode reloads from the load value on reaching zero.
// R4: One-shot mode counts down from a new load, then stops until reloaded.
// R5: Shared timer clock, each counter qualified by its own clock enable.
// R6: Per-counter prescaler divides the enabled timer rate by 1, 16 or 256.
// R7: Writing the load value restarts the count from it.
// R8: Background load changes only the reload value, count keeps running.
// R9: Reaching zero raises an interrupt held until software clears it.
// R10: A mask bit suppresses each timer's interrupt output.
// R11: Current count readable at any time without disturbing it.
// R12: Reset may assert asynchronously but releases on a clock edge.
// R13: Reset is held low for at least one clock period.
// R14: Reset state: disabled, free-running, 16-bit, /1, irq enabled, load zero.
// R15: Prescaler steps only on enabled timer clock edges.
// R16: Counter steps only on enabled edges with a prescaler pulse.
// R17: Registers run on the bus clock, counting on the qualified timer clock.
// R18: Timer clock is no faster than, and edge-aligned with, the bus clock; the pin filter here takes at most a quarter of the bus clock.
// R19: Read-only identification registers.
// R20: Bus slave decodes every register access.
// R21: Interrupt clear drops the output at once, not on a timer edge.
// R22: 16-bit free-running counts low half, wraps it to 0xffff.
// R23: One-shot select overrides the periodic select.
// R24: Raw and masked interrupt status are both readable.
// R25: Timer logic samples configuration directly, no extra synchroniser.
module ddt_top import ddt_pkg::*; #(
  parameter logic [DW-1:0] ID0_VAL = 32'h0000_00d1, // Arbitrary value
  parameter logic [DW-1:0] ID1_VAL = 32'h0000_00e2  // Arbitrary value
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [DW-1:0] pwdata,
  output logic      [DW-1:0] prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          timer_clock,
  input  wire logic          first_timer_clock_enable,
  input  wire logic          second_timer_clock_enable,
  output logic      [1:0]    timer_interrupt_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: bit 0 timer clock, bits 1 and 2 the clock enables
  logic [2:0]        sy1_r;
  logic [2:0]        sy2_r;
  logic [2:0]        sy3_r;
  logic [2:0]        flt_r;
  logic [2:0]        flt_nxt;
  logic [1:0]        tick_r;
  logic [1:0]        tick_nxt;

  // Bus side state
  logic [CTRL_W-1:0] ctrl_r   [2];
  logic [CTRL_W-1:0] ctrl_nxt [2];
  logic [DW-1:0]     prdata_r;
  logic [DW-1:0]     prdata_nxt;
  logic              pready_r;
  logic              pready_nxt;
  logic              pslverr_r;
  logic              pslverr_nxt;

  // Decode results
  logic              setup;
  logic              wr;
  logic              tsel;
  logic              in_tmr;
  logic              bad;
  logic [OFS_W-1:0]  ofs;
  logic [DW-1:0]     rd;
  logic [1:0]        load_wr;
  logic [1:0]        bg_wr;
  logic [1:0]        clr;

  // Counter unit outputs
  logic [DW-1:0]     cnt [2];
  logic [DW-1:0]     ld  [2];
  logic [1:0]        raw;
  logic [1:0]        irq;

  ////////////////////////////////////////////////////////////////////////////
  // Timer clock and enables cross in by three flops; a level counts once
  // the second and third agree. Limits the timer clock to a quarter of clk.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      flt_nxt[i] = (sy2_r[i] == sy3_r[i]) ? sy3_r[i] : flt_r[i];
    end
    // One tick per enabled rising timer clock edge
    tick_nxt[0] = flt_nxt[0] & ~flt_r[0] & flt_r[1];                    // [R5]
    tick_nxt[1] = flt_nxt[0] & ~flt_r[0] & flt_r[2];                    // [R17]
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sy1_r  <= '0;
      sy2_r  <= '0;
      sy3_r  <= '0;
      flt_r  <= '0;
      tick_r <= '0;
    end else begin
      sy1_r  <= {second_timer_clock_enable, first_timer_clock_enable, timer_clock};
      sy2_r  <= sy1_r;
      sy3_r  <= sy2_r;
      flt_r  <= flt_nxt;
      tick_r <= tick_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register decode; one access phase with no wait state
  always_comb begin
    setup       = psel & ~penable;
    wr          = psel & penable & pwrite & pready_r;
    tsel        = paddr[TSEL_BIT];
    in_tmr      = (paddr[AW-1:TSEL_BIT+1] == '0);
    ofs         = paddr[OFS_W-1:0];
    rd          = '0;
    bad         = 1'b0;
    load_wr     = '0;
    bg_wr       = '0;
    clr         = '0;
    ctrl_nxt[0] = ctrl_r[0];
    ctrl_nxt[1] = ctrl_r[1];
    if (in_tmr && ofs == OFS_LOAD) begin                                // [R20]
      rd            = ld[tsel];
      load_wr[tsel] = wr;                                               // [R7]
    end else if (in_tmr && ofs == OFS_VALUE) begin
      rd = cnt[tsel];                                                   // [R11]
    end else if (in_tmr && ofs == OFS_CTRL) begin
      rd = DW'(ctrl_r[tsel]);
      if (wr) begin
        ctrl_nxt[tsel] = pwdata[CTRL_W-1:0];
      end
    end else if (in_tmr && ofs == OFS_INTCLR) begin
      clr[tsel] = wr;                                                   // [R9]
    end else if (in_tmr && ofs == OFS_RIS) begin
      rd = DW'(raw[tsel]);                                              // [R24]
    end else if (in_tmr && ofs == OFS_MIS) begin
      rd = DW'(irq[tsel]);                                              // [R24]
    end else if (in_tmr && ofs == OFS_BGLOAD) begin
      rd          = ld[tsel];
      bg_wr[tsel] = wr;                                                 // [R8]
    end else if (paddr == ADDR_ID0) begin
      rd = ID0_VAL;                                                     // [R19]
    end else if (paddr == ADDR_ID1) begin
      rd = ID1_VAL;                                                     // [R19]
    end else begin
      bad = 1'b1;
    end
    pready_nxt  = setup;
    pslverr_nxt = setup & bad;
    prdata_nxt  = (setup && !pwrite) ? rd : prdata_r;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r[0] <= CTRL_RST;                                            // [R14]
      ctrl_r[1] <= CTRL_RST;
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      ctrl_r[0] <= ctrl_nxt[0];
      ctrl_r[1] <= ctrl_nxt[1];
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Both clocks share edges, so control bits feed the counters directly
  for (genvar k = 0; k < 2; k++) begin : g_unit
    ddt_counter_unit u_cnt (
      .clk      (clk),
      .rst_b    (rst_b),
      .tick     (tick_r[k]),
      .en       (ctrl_r[k][CTL_EN]),                                    // [R25]
      .single_run_select  (ctrl_r[k][CTL_SINGLE_RUN_SELECT]),
      .periodic (ctrl_r[k][CTL_PERIODIC]),
      .size32   (ctrl_r[k][CTL_SIZE32]),
      .pre_sel  (ctrl_r[k][CTL_PRE_HI:CTL_PRE_LO]),
      .int_en   (ctrl_r[k][CTL_INTEN]),                                 // [R10]
      .load_wr  (load_wr[k]),
      .bg_wr    (bg_wr[k]),
      .wdata    (pwdata),
      .int_clr  (clr[k]),                                               // [R21]
      .cnt_r    (cnt[k]),
      .load_r   (ld[k]),
      .raw_r    (raw[k]),
      .irq_r    (irq[k])
    );
    assign timer_interrupt_out[k] = irq[k];
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_ready;
    @(posedge clk) disable iff (!rst_b) setup |=> pready_r ##1 !pready_r;
  endproperty
  a_ready: assert property (p_ready) else $error("no single-cycle ready"); // [R20]

  property p_unmapped;
    @(posedge clk) disable iff (!rst_b)
      setup && !in_tmr && paddr != ADDR_ID0 && paddr != ADDR_ID1 |=> pslverr_r && pready_r;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused"); // [R20]

  property p_id;
    @(posedge clk) disable iff (!rst_b)
      setup && !pwrite && paddr == ADDR_ID0 |=> prdata_r == ID0_VAL && !pslverr_r;
  endproperty
  a_id: assert property (p_id) else $error("identification read wrong"); // [R19]

  property p_value;
    @(posedge clk) disable iff (!rst_b)
      setup && !pwrite && in_tmr && ofs == OFS_VALUE && !tsel |=> prdata_r == $past(cnt[0]);
  endproperty
  a_value: assert property (p_value) else $error("count read wrong"); // [R11]

  property p_ctrl_wr;
    @(posedge clk) disable iff (!rst_b)
      wr && in_tmr && ofs == OFS_CTRL && tsel |=> ctrl_r[1] == $past(pwdata[CTRL_W-1:0]);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost"); // [R20]

  property p_tick_en;
    @(posedge clk) disable iff (!rst_b) tick_r[1] |-> $past(flt_r[2]) && !$past(flt_r[0]);
  endproperty
  a_tick_en: assert property (p_tick_en) else $error("tick without enable"); // [R5]

  property p_mis;
    @(posedge clk) disable iff (!rst_b)
      setup && !pwrite && in_tmr && ofs == OFS_MIS && !tsel |=> prdata_r[0] == $past(irq[0]);
  endproperty
  a_mis: assert property (p_mis) else $error("masked status wrong"); // [R24]

  property p_mask;
    @(posedge clk) disable iff (!rst_b)
      !ctrl_r[0][CTL_INTEN] && $stable(ctrl_r[0]) |-> !timer_interrupt_out[0];
  endproperty
  a_mask: assert property (p_mask) else $error("masked irq visible"); // [R10]

  property p_err_ready;
    @(posedge clk) disable iff (!rst_b) pslverr_r |-> pready_r;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready"); // [R20]

  property p_ready_src;
    @(posedge clk) disable iff (!rst_b) pready_r |-> $past(setup);
  endproperty
  a_ready_src: assert property (p_ready_src) else $error("ready without setup"); // [R20]

  property p_rdata_hold;
    @(posedge clk) disable iff (!rst_b) !(setup && !pwrite) |=> $stable(prdata_r);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved"); // [R20]

  property p_ctrl_hold;
    @(posedge clk) disable iff (!rst_b) !wr |=> $stable(ctrl_r[0]) && $stable(ctrl_r[1]);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed"); // [R20]

  property p_mapped_ok;
    @(posedge clk) disable iff (!rst_b) setup && in_tmr && ofs == OFS_CTRL |=> !pslverr_r;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access refused"); // [R20]

  property p_tick0_en;
    @(posedge clk) disable iff (!rst_b) tick_r[0] |-> $past(flt_r[1]) && !$past(flt_r[0]);
  endproperty
  a_tick0_en: assert property (p_tick0_en) else $error("tick without enable"); // [R5]

  property p_tick_once;
    @(posedge clk) disable iff (!rst_b) tick_r[0] |=> !tick_r[0];
  endproperty
  a_tick_once: assert property (p_tick_once) else $error("tick repeated"); // [R15]

  property p_filter;
    @(posedge clk) disable iff (!rst_b)
      $past(sy2_r) == $past(sy3_r) |-> flt_r == $past(sy3_r);
  endproperty
  a_filter: assert property (p_filter) else $error("filter missed agreement"); // [R5]

  property p_irq_out;
    @(posedge clk) disable iff (!rst_b)
      $stable(ctrl_r[1]) |-> timer_interrupt_out[1] == (raw[1] && ctrl_r[1][CTL_INTEN]);
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("interrupt output wrong"); // [R10]

endmodule
`default_nettype wire

//--- verif/ddt_timer_source.sv
`timescale 1ns/1ps
`default_nettype none
module ddt_timer_source (
  input  wire logic       clk,
  input  wire logic       rst_b,
  output logic            timer_clock,
  output logic      [1:0] enables
);
  logic [1:0] phase_r;

  ////////////////////////////////////////////////////////////////////////////
  // Quarter of the bus rate, rising edges land on bus clock rising edges
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end
  assign timer_clock = phase_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Enables move only on falling timer edges, so they never straddle a rising one
  initial enables = 2'h0;

  task automatic run(input logic [1:0] sel, input int n);
    @(negedge timer_clock);
    enables <= sel;
    repeat (n) @(posedge timer_clock);
    @(negedge timer_clock);
    enables <= 2'h0;
    // Pin sampling plus tick pipeline must settle before software looks
    repeat (12) @(posedge clk);
  endtask
endmodule
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ddt_pkg::*;
  localparam logic [DW-1:0] ID0 = 32'h0000_0a5a; // Arbitrary value
  localparam logic [DW-1:0] ID1 = 32'h0000_0b6b; // Arbitrary value
  localparam logic [AW-1:0] T0  = 12'h000;
  localparam logic [AW-1:0] T1  = 12'h020;
  logic          clk;
  logic          rst_b;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [AW-1:0] paddr;
  logic [DW-1:0] pwdata;
  logic [DW-1:0] prdata;
  logic          pready;
  logic          pslverr;
  logic          timer_clock;
  logic [1:0]    enables;
  logic [1:0]    irq;
  int            mismatches;
  int            tests_run;
  logic [DW-1:0] v1;
  logic [DW-1:0] v2;
  logic          err;

  ddt_top #(.ID0_VAL(ID0), .ID1_VAL(ID1)) uut (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_clock(timer_clock), .first_timer_clock_enable(enables[0]),
    .second_timer_clock_enable(enables[1]), .timer_interrupt_out(irq));

  ddt_timer_source tcs (.clk(clk), .rst_b(rst_b), .timer_clock(timer_clock), .enables(enables));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask

  // Master holds the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d,
                     output logic [DW-1:0] r, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    logic [DW-1:0] r;
    logic          e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] r);
    logic e;
    apb(1'b0, a, '0, r, e);
  endtask

  task automatic chk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    logic [DW-1:0] r;
    rd(a, r);
    cmp(r, exp);
  endtask

  task automatic chk_irq(input logic [1:0] exp);
    @(negedge clk);
    cmp({30'h0, irq}, {30'h0, exp});
  endtask

  function automatic logic [DW-1:0] cw(input logic e, input logic p, input logic o,
                                       input logic s, input logic ie, input logic [1:0] pre);
    cw = '0;
    cw[CTL_EN] = e;
    cw[CTL_PERIODIC] = p;
    cw[CTL_SINGLE_RUN_SELECT] = o;
    cw[CTL_SIZE32] = s;
    cw[CTL_INTEN] = ie;
    cw[CTL_PRE_HI:CTL_PRE_LO] = pre;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mismatches = 0;
    tests_run = 0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1; // Released on the fourth rising edge
    // Disabled after reset: enabled pins alone must not move the count
    tcs.run(2'h3, 3);
    chk(T0 | OFS_CTRL, {24'h0, CTRL_RST});
    chk(T1 | OFS_CTRL, {24'h0, CTRL_RST});
    chk(T0 | OFS_LOAD, LOAD_RST);
    chk(T0 | OFS_VALUE, VALUE_RST);
    chk(T1 | OFS_VALUE, VALUE_RST);
    chk(T1 | OFS_RIS, 32'h0);
    chk(ADDR_ID0, ID0);
    chk(ADDR_ID1, ID1);
    apb(1'b0, 12'h800, '0, v1, err);
    cmp({31'h0, err}, 32'h1);
    // Periodic 16-bit, divide by 1
    wr(T0 | OFS_CTRL, cw(1, 1, 0, 0, 1, 2'h0));
    wr(T0 | OFS_LOAD, 32'h3);
    tcs.run(2'h1, 1);
    chk(T0 | OFS_VALUE, 32'h3);
    tcs.run(2'h1, 3);
    chk(T0 | OFS_VALUE, 32'h0);
    chk(T0 | OFS_RIS, 32'h0);
    tcs.run(2'h1, 1);
    chk(T0 | OFS_VALUE, 32'h3);
    chk(T0 | OFS_RIS, 32'h1);
    chk(T0 | OFS_MIS, 32'h1);
    wr(T0 | OFS_BGLOAD, 32'h5);
    chk(T0 | OFS_VALUE, 32'h3);
    chk(T0 | OFS_LOAD, 32'h5);
    tcs.run(2'h1, 4);
    chk(T0 | OFS_VALUE, 32'h5);
    chk_irq(2'h1);
    wr(T0 | OFS_INTCLR, 32'h0);
    @(posedge clk);
    chk_irq(2'h0);
    chk(T0 | OFS_RIS, 32'h0);
    wr(T0 | OFS_LOAD, 32'h2);
    tcs.run(2'h1, 1);
    chk(T0 | OFS_VALUE, 32'h2);
    // Masked interrupt still shows in the raw status
    wr(T0 | OFS_CTRL, cw(1, 1, 0, 0, 0, 2'h0));
    tcs.run(2'h1, 3);
    chk(T0 | OFS_RIS, 32'h1);
    chk(T0 | OFS_MIS, 32'h0);
    chk_irq(2'h0);
    wr(T0 | OFS_INTCLR, 32'h0);
    // Second timer, free-running 16-bit; first timer's pin stays low
    wr(T1 | OFS_CTRL, cw(1, 0, 0, 0, 1, 2'h0));
    wr(T1 | OFS_LOAD, 32'h0001_0002);
    tcs.run(2'h2, 1);
    chk(T1 | OFS_VALUE, 32'h0001_0002);
    chk(T0 | OFS_VALUE, 32'h2);
    tcs.run(2'h2, 3);
    chk(T1 | OFS_VALUE, 32'h0001_ffff);
    chk_irq(2'h2);
    wr(T1 | OFS_INTCLR, 32'h0);
    // Free-running 32-bit wraps to the full reset value
    wr(T1 | OFS_CTRL, cw(1, 0, 0, 1, 1, 2'h0));
    wr(T1 | OFS_LOAD, 32'h1);
    tcs.run(2'h2, 3);
    chk(T1 | OFS_VALUE, WRAP32);
    // Periodic 32-bit reloads the whole word from a background load
    wr(T1 | OFS_CTRL, cw(1, 1, 0, 1, 1, 2'h0));
    wr(T1 | OFS_LOAD, 32'h2);
    tcs.run(2'h2, 1);
    wr(T1 | OFS_BGLOAD, 32'h0003_0000);
    tcs.run(2'h2, 3);
    chk(T1 | OFS_VALUE, 32'h0003_0000);
    // One-shot with the periodic select also set must halt at zero
    wr(T1 | OFS_CTRL, cw(1, 1, 1, 0, 1, 2'h0));
    wr(T1 | OFS_LOAD, 32'h2);
    tcs.run(2'h2, 6);
    chk(T1 | OFS_VALUE, 32'h0);
    wr(T1 | OFS_LOAD, 32'h4);
    tcs.run(2'h2, 1);
    chk(T1 | OFS_VALUE, 32'h4);
    // Prescaler: one decrement for each full division span
    for (int k = 1; k <= 3; k++) begin
      wr(T0 | OFS_CTRL, cw(1, 0, 0, 0, 0, k[1:0]));
      wr(T0 | OFS_LOAD, 32'h100);
      tcs.run(2'h1, 41);
      rd(T0 | OFS_VALUE, v1);
      tcs.run(2'h1, (k == 1) ? 16 : 256);
      rd(T0 | OFS_VALUE, v2);
      cmp(v1 - v2, 32'h1);
    end
    test_done();
  end
endmodule
`default_nettype wire
